/* File: ivu_arbiter.sv */
/*
 * fixed-order arbiter: lowest order wins within each priority level.
 * assumes req is already gated by the enables.
 */
`timescale 1ns/1ps

module ivu_arbiter #(
   parameter int N  = 21,
   parameter int OW = 5
) (
   // requests
   input  wire logic [N-1:0]  req,
   input  wire logic [N-1:0]  high,
   // winners
   output logic               hit_hi,
   output logic [OW-1:0]      ord_hi,
   output logic               hit_lo,
   output logic [OW-1:0]      ord_lo
);

   // =======================================================================
   // scan from the top so the lowest order is left standing
   always_comb begin
      hit_hi = 1'b0;
      ord_hi = '0;
      hit_lo = 1'b0;
      ord_lo = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && high[i]) begin
            hit_hi = 1'b1;
            ord_hi = OW'(i);
         end
         if (req[i] && !high[i]) begin
            hit_lo = 1'b1;
            ord_lo = OW'(i);
         end
      end
   end

endmodule // ivu_arbiter

/* File: ivu_core_model.sv */
/*
 * core sequencer model: instruction-end and return-from-interrupt pulses.
 * assumes the unit's pclk, presetn and lcall_active.
 */
`timescale 1ns/1ps

module ivu_core_model (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic lcall_active,
   input  wire logic reti_req,
   input  wire logic slow,
   // pulses
   output logic      core_instr_done,
   output logic      core_reti
);
   logic [1:0] gap_reg;
   logic       ret_reg;

   // ======================================================================
   // no instruction ends while the long call runs; return wins a free slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg         <= 2'h0;
         ret_reg         <= 1'b0;
         core_instr_done <= 1'b0;
         core_reti       <= 1'b0;
      end else begin
         core_instr_done <= 1'b0;
         core_reti       <= 1'b0;
         if (reti_req) begin
            ret_reg <= 1'b1;
         end
         if (!lcall_active) begin
            if (ret_reg) begin
               core_reti <= 1'b1;
               ret_reg   <= 1'b0;
            end else if (gap_reg == 2'h0) begin
               core_instr_done <= 1'b1;
               gap_reg         <= slow ? 2'h2 : 2'h0;
            end else begin
               gap_reg <= gap_reg - 2'h1;
            end
         end
      end
   end
endmodule // ivu_core_model

/* File: ivu_ext_pin.sv */
/*
 * one external interrupt pin: level or falling-edge trigger and its
 * pending flag.
 * assumes the pin is synchronous to pclk and active low.
 */
`timescale 1ns/1ps
`include "ivu_regs.svh"

module ivu_ext_pin (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // pin and control
   input  wire logic pin_n,
   input  wire logic edge_mode,
   input  wire logic vector_ack,
   input  wire logic sw_we,
   input  wire logic sw_val,
   // flag
   output logic      pending
);
   import ivu_pkg::*;

   ivu_pin_s st_reg;
   ivu_pin_s st_next;
   logic     fall;

   // =======================================================================
   // next state
   always_comb begin
      st_next = st_reg;
      st_next.pin_prev = pin_n;
      fall = st_reg.pin_prev & ~pin_n;
      if (!edge_mode) begin
         st_next.pend = ~pin_n;
      end else if (fall) begin
         st_next.pend = 1'b1;
      end else if (vector_ack || (sw_we && !sw_val)) begin
         st_next.pend = 1'b0;
      end else if (sw_we) begin
         st_next.pend = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{pin_prev: 1'b1, pend: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pending = st_reg.pend;

   // =======================================================================
   // checks
   property p_edge_set;
      @(posedge pclk) disable iff (!presetn)
      (edge_mode && st_reg.pin_prev && !pin_n) |=> pending;
   endproperty
   a_edge_set: assert property (p_edge_set)
      else $error("falling edge did not set the pending flag");

   property p_level_track;
      @(posedge pclk) disable iff (!presetn)
      !edge_mode |=> (pending == !$past(pin_n));
   endproperty
   a_level_track: assert property (p_level_track)
      else $error("level pending flag does not follow the pin");

endmodule // ivu_ext_pin

/* File: ivu_pkg.sv */
/*
 * types of the two-level vectored interrupt unit: sequencer states and the
 * packed state records of the pin and top modules.
 * assumes ivu_regs.svh is on the include path.
 */
`include "ivu_regs.svh"

package ivu_pkg;

   // =======================================================================
   // sequencer states
   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_CALL = 1'b1
   } ivu_seq_e;

   // =======================================================================
   // state records
   typedef struct packed {
      logic pin_prev;
      logic pend;
   } ivu_pin_s;

   typedef struct packed {
      logic                  type_a;
      logic                  type_b;
      logic                  ta_ovf;
      logic                  tb_ovf;
      logic [7:0]            ie;
      logic [7:0]            ee1;
      logic [7:0]            ee2;
      logic [7:0]            ip;
      logic [7:0]            ep1;
      logic [7:0]            ep2;
      logic [`IVU_NSRC-1:0]  pend;
      ivu_seq_e              seq;
      logic [2:0]            cnt;
      logic                  act_lo;
      logic                  act_hi;
      logic                  won_valid;
      logic                  won_high;
      logic [4:0]            won_order;
      logic                  lcall_active;
      logic [15:0]           lcall_vector;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } ivu_top_s;

endpackage : ivu_pkg

/* File: ivu_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * two-level vectored interrupt unit.
 * assumes a 32-bit apb slave with an 8-bit byte address.
 */
`ifndef IVU_REGS_SVH
`define IVU_REGS_SVH

// ==========================================================================
// register byte offsets
`define IVU_OFS_TIMER_CONTROL_REG     8'h00
`define IVU_OFS_IE       8'h04
`define IVU_OFS_EE1      8'h08
`define IVU_OFS_EE2      8'h0C
`define IVU_OFS_IP       8'h10
`define IVU_OFS_EP1      8'h14
`define IVU_OFS_EP2      8'h18
`define IVU_OFS_PEND     8'h1C
`define IVU_OFS_STAT     8'h20

// ==========================================================================
// field positions
`define IVU_TC_A_TYPE    0
`define IVU_TC_A_PEND    1
`define IVU_TC_B_TYPE    2
`define IVU_TC_B_PEND    3
`define IVU_TC_TA_OVF    5
`define IVU_TC_TB_OVF    7
`define IVU_IE_GLOBAL    7
`define IVU_ST_ACT_LO    0
`define IVU_ST_ACT_HI    1
`define IVU_ST_CALL      2
`define IVU_ST_WVALID    3
`define IVU_ST_ORD_LSB   8

// ==========================================================================
// sources, vectors, timing
`define IVU_NSRC         21
`define IVU_ORD_PIN_A    5'h00
`define IVU_ORD_TMR_A    5'h01
`define IVU_ORD_PIN_B    5'h02
`define IVU_ORD_TMR_B    5'h03
`define IVU_SW_PEND_MASK 21'h17FFF0
`define IVU_SRC_MASK     21'h17FFFF
`define IVU_VEC_BASE     16'h0003
`define IVU_VEC_SHIFT    3
`define IVU_CALL_CLKS    3'h4
`define IVU_RST_ZERO     32'h00000000

`endif

/* File: ivu_top.sv */
/*
 * two-level vectored interrupt unit: apb registers, external pin flags,
 * pending flags, priority decode and the long-call sequencer.
 * assumes the core pulses core_instr_done at each instruction end and
 * core_reti when a return-from-interrupt completes; never both at once.
 */
`timescale 1ns/1ps
`include "ivu_regs.svh"

module ivu_top (
   // apb slave
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // external pins
   input  wire logic                  ext_irq_pin_a_n,
   input  wire logic                  ext_irq_pin_b_n,
   // source events
   input  wire logic                  timer_a_ovf_set,
   input  wire logic                  timer_b_ovf_set,
   input  wire logic [`IVU_NSRC-1:0]  periph_irq_set,
   // core sequencer
   input  wire logic                  core_instr_done,
   input  wire logic                  core_reti,
   output logic                       lcall_active,
   output logic      [15:0]           lcall_vector
);
   import ivu_pkg::*;

   ivu_top_s              st;
   ivu_top_s              nx;
   logic                  pin_a_pending;
   logic                  pin_b_pending;
   logic [`IVU_NSRC-1:0]  pend_all;
   logic [`IVU_NSRC-1:0]  en_vec;
   logic [`IVU_NSRC-1:0]  hi_vec;
   logic [`IVU_NSRC-1:0]  eligible;
   logic                  hit_hi;
   logic                  hit_lo;
   logic [4:0]            ord_hi;
   logic [4:0]            ord_lo;
   logic                  acc;
   logic                  wr;
   logic                  tc_we;
   logic                  grant;
   logic                  ack_a;
   logic                  ack_b;
   logic                  ack_ta;
   logic                  ack_tb;
   logic [7:0]            tc_rd;
   logic [31:0]           st_rd;
   logic [31:0]           rd;
   logic                  hit;

   // =======================================================================
   // external pins
   ivu_ext_pin u_pin_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_n      (ext_irq_pin_a_n),
      .edge_mode  (st.type_a),
      .vector_ack (ack_a),
      .sw_we      (tc_we),
      .sw_val     (pwdata[`IVU_TC_A_PEND]),
      .pending    (pin_a_pending)
   );

   ivu_ext_pin u_pin_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_n      (ext_irq_pin_b_n),
      .edge_mode  (st.type_b),
      .vector_ack (ack_b),
      .sw_we      (tc_we),
      .sw_val     (pwdata[`IVU_TC_B_PEND]),
      .pending    (pin_b_pending)
   );

   // =======================================================================
   // request vectors and arbitration
   always_comb begin
      pend_all = st.pend;
      pend_all[`IVU_ORD_PIN_A] = pin_a_pending;
      pend_all[`IVU_ORD_TMR_A] = st.ta_ovf;
      pend_all[`IVU_ORD_PIN_B] = pin_b_pending;
      pend_all[`IVU_ORD_TMR_B] = st.tb_ovf;
      en_vec   = {st.ee2[6:0], st.ee1, st.ie[5:0]};
      hi_vec   = {st.ep2[6:0], st.ep1, st.ip[5:0]};
      eligible = pend_all & en_vec & `IVU_SRC_MASK
               & {`IVU_NSRC{st.ie[`IVU_IE_GLOBAL]}};
   end

   ivu_arbiter #(
      .N  (`IVU_NSRC),
      .OW (5)
   ) u_arb (
      .req    (eligible),
      .high   (hi_vec),
      .hit_hi (hit_hi),
      .ord_hi (ord_hi),
      .hit_lo (hit_lo),
      .ord_lo (ord_lo)
   );

   // =======================================================================
   // grant and hardware clears
   always_comb begin
      grant  = (st.seq == ST_RUN) && core_instr_done && st.won_valid;
      ack_a  = grant && (st.won_order == `IVU_ORD_PIN_A);
      ack_ta = grant && (st.won_order == `IVU_ORD_TMR_A);
      ack_b  = grant && (st.won_order == `IVU_ORD_PIN_B);
      ack_tb = grant && (st.won_order == `IVU_ORD_TMR_B);
   end

   // =======================================================================
   // register read view
   always_comb begin
      tc_rd = '0;
      tc_rd[`IVU_TC_A_TYPE] = st.type_a;
      tc_rd[`IVU_TC_A_PEND] = pin_a_pending;
      tc_rd[`IVU_TC_B_TYPE] = st.type_b;
      tc_rd[`IVU_TC_B_PEND] = pin_b_pending;
      tc_rd[`IVU_TC_TA_OVF] = st.ta_ovf;
      tc_rd[`IVU_TC_TB_OVF] = st.tb_ovf;
      st_rd = '0;
      st_rd[`IVU_ST_ACT_LO] = st.act_lo;
      st_rd[`IVU_ST_ACT_HI] = st.act_hi;
      st_rd[`IVU_ST_CALL]   = st.lcall_active;
      st_rd[`IVU_ST_WVALID] = st.won_valid;
      st_rd[`IVU_ST_ORD_LSB +: 5] = st.won_order;
      hit = 1'b1;
      rd  = '0;
      unique case (paddr)
         `IVU_OFS_TIMER_CONTROL_REG: rd = {24'h000000, tc_rd};
         `IVU_OFS_IE:   rd = {24'h000000, st.ie};
         `IVU_OFS_EE1:  rd = {24'h000000, st.ee1};
         `IVU_OFS_EE2:  rd = {24'h000000, st.ee2};
         `IVU_OFS_IP:   rd = {24'h000000, st.ip};
         `IVU_OFS_EP1:  rd = {24'h000000, st.ep1};
         `IVU_OFS_EP2:  rd = {24'h000000, st.ep2};
         `IVU_OFS_PEND: rd = {11'h000, pend_all};
         `IVU_OFS_STAT: rd = st_rd;
         default:       hit = 1'b0;
      endcase
   end

   // =======================================================================
   // next state
   always_comb begin
      nx    = st;
      acc   = psel && penable && st.pready;
      wr    = acc && pwrite;
      tc_we = wr && (paddr == `IVU_OFS_TIMER_CONTROL_REG);

      // apb: answer in the access phase, zero wait states
      nx.pready  = psel && !penable;
      nx.pslverr = psel && !penable && !hit;
      nx.prdata  = (psel && !penable && !pwrite) ? rd : `IVU_RST_ZERO;
      if (wr) begin
         unique case (paddr)
            `IVU_OFS_TIMER_CONTROL_REG: begin
               nx.type_a = pwdata[`IVU_TC_A_TYPE];
               nx.type_b = pwdata[`IVU_TC_B_TYPE];
            end
            `IVU_OFS_IE:   nx.ie  = pwdata[7:0];
            `IVU_OFS_EE1:  nx.ee1 = pwdata[7:0];
            `IVU_OFS_EE2:  nx.ee2 = pwdata[7:0];
            `IVU_OFS_IP:   nx.ip  = pwdata[7:0];
            `IVU_OFS_EP1:  nx.ep1 = pwdata[7:0];
            `IVU_OFS_EP2:  nx.ep2 = pwdata[7:0];
            `IVU_OFS_PEND: nx.pend = pwdata[`IVU_NSRC-1:0] & `IVU_SW_PEND_MASK;
            default: ;
         endcase
      end

      // timer flags: set wins over any clear
      if (tc_we) begin
         nx.ta_ovf = pwdata[`IVU_TC_TA_OVF];
         nx.tb_ovf = pwdata[`IVU_TC_TB_OVF];
      end else begin
         nx.ta_ovf = st.ta_ovf && !ack_ta;
         nx.tb_ovf = st.tb_ovf && !ack_tb;
      end
      nx.ta_ovf = nx.ta_ovf || timer_a_ovf_set;
      nx.tb_ovf = nx.tb_ovf || timer_b_ovf_set;
      nx.pend   = nx.pend | (periph_irq_set & `IVU_SW_PEND_MASK);

      // detect: decode every clock against the active service level
      nx.won_valid = (hit_hi && !st.act_hi)
                  || (hit_lo && !st.act_hi && !st.act_lo);
      nx.won_high  = hit_hi && !st.act_hi;
      nx.won_order = (hit_hi && !st.act_hi) ? ord_hi : ord_lo;

      // long-call sequencer
      unique case (st.seq)
         ST_RUN: begin
            if (core_reti) begin
               // no call at the return itself: next instruction runs first
               if (st.act_hi) begin
                  nx.act_hi = 1'b0;
               end else begin
                  nx.act_lo = 1'b0;
               end
               nx.won_valid = 1'b0;
            end else if (grant) begin
               nx.seq          = ST_CALL;
               nx.cnt          = `IVU_CALL_CLKS - 3'h1;
               nx.lcall_active = 1'b1;
               nx.lcall_vector = `IVU_VEC_BASE
                  + ({11'h000, st.won_order} << `IVU_VEC_SHIFT);
               nx.won_valid    = 1'b0;
               if (st.won_high) begin
                  nx.act_hi = 1'b1;
               end else begin
                  nx.act_lo = 1'b1;
               end
            end
         end
         ST_CALL: begin
            nx.won_valid = 1'b0;
            if (st.cnt == 3'h0) begin
               nx.seq          = ST_RUN;
               nx.lcall_active = 1'b0;
            end else begin
               nx.cnt = st.cnt - 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign prdata       = st.prdata;
   assign pready       = st.pready;
   assign pslverr      = st.pslverr;
   assign lcall_active = st.lcall_active;
   assign lcall_vector = st.lcall_vector;

   // =======================================================================
   // checks
   property p_call_len;
      @(posedge pclk) disable iff (!presetn)
      $rose(lcall_active) |-> lcall_active [*4] ##1 !lcall_active;
   endproperty
   a_call_len: assert property (p_call_len)
      else $error("long call did not last four clocks");

   property p_vec_form;
      @(posedge pclk) disable iff (!presetn)
      $rose(lcall_active) |-> (lcall_vector[2:0] == 3'h3)
         && (lcall_vector != 16'h009B) && (lcall_vector <= 16'h00A3);
   endproperty
   a_vec_form: assert property (p_vec_form)
      else $error("vector address outside the table");

   property p_no_preempt_hi;
      @(posedge pclk) disable iff (!presetn)
      $rose(lcall_active) |-> !$past(st.act_hi) && st.act_hi | st.act_lo;
   endproperty
   a_no_preempt_hi: assert property (p_no_preempt_hi)
      else $error("call started while high service active");

   property p_global_off;
      @(posedge pclk) disable iff (!presetn)
      !st.ie[`IVU_IE_GLOBAL] |=> !st.won_valid ##1 !$rose(lcall_active);
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("request raised with global enable clear");

   property p_reti_gap;
      @(posedge pclk) disable iff (!presetn)
      (core_reti && st.seq == ST_RUN) |=> !lcall_active ##1 !$rose(lcall_active);
   endproperty
   a_reti_gap: assert property (p_reti_gap)
      else $error("call issued without an instruction after return");

   property p_tmr_a_clear;
      @(posedge pclk) disable iff (!presetn)
      ($rose(lcall_active) && lcall_vector == 16'h000B
         && !$past(timer_a_ovf_set) && !$past(tc_we)) |-> !st.ta_ovf;
   endproperty
   a_tmr_a_clear: assert property (p_tmr_a_clear)
      else $error("timer a flag not cleared on vectoring");

endmodule // ivu_top

/* File: tb_two_level_vectored_interrupt_unit.sv */
/*
 * self-checking bench of the interrupt unit: apb master, sources, core model.
 * assumes ivu_regs.svh on the include path.
 */
`timescale 1ns/1ps
`include "ivu_regs.svh"

module tb_two_level_vectored_interrupt_unit;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata, rng;
   logic                 pin_a_n, pin_b_n, tmr_a, tmr_b, instr_done, reti;
   logic                 lcall, prev, reti_req, slow;
   logic [`IVU_NSRC-1:0] pset;
   logic [15:0]          vec;
   logic [32:0]          rdq[$];
   logic [15:0]          vq[$];
   int                   errors, compares, ncalls, len, cyc, o;

   ivu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin_a_n(pin_a_n), .ext_irq_pin_b_n(pin_b_n),
      .timer_a_ovf_set(tmr_a), .timer_b_ovf_set(tmr_b), .periph_irq_set(pset),
      .core_instr_done(instr_done), .core_reti(reti), .lcall_active(lcall),
      .lcall_vector(vec));
   ivu_core_model core_u (.pclk(pclk), .presetn(presetn), .lcall_active(lcall),
      .reti_req(reti_req), .slow(slow), .core_instr_done(instr_done), .core_reti(reti));

   // ======================================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is sampled at the rising edge; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rdq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic pulse_tmr(input logic [1:0] t);
      @(posedge pclk);
      tmr_a <= t[0];
      tmr_b <= t[1];
      @(posedge pclk);
      tmr_a <= 1'b0;
      tmr_b <= 1'b0;
   endtask
   task automatic set_pins(input logic [1:0] v);
      pin_a_n <= v[0];
      pin_b_n <= v[1];
   endtask
   task automatic wait_call(input int k);
      int n;
      n = 0;
      while ((ncalls < k || lcall !== 1'b0) && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n == 300) errors++;
   endtask
   // service routine body: one write, then return
   task automatic isr(input int k, input logic [7:0] a, input logic [31:0] d);
      wait_call(k);
      apb(1'b1, a, d);
      @(posedge pclk);
      reti_req <= 1'b1;
      @(posedge pclk);
      reti_req <= 1'b0;
   endtask
   task automatic test_done();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ======================================================================
   // clock, timeout, monitors
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end
   // read data is taken at the same rising edge that sees pready
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0)
         chk({pslverr, prdata}, rdq.pop_front());
   end
   always @(negedge pclk) begin
      if (lcall === 1'b1 && !prev) begin
         ncalls++;
         len = 0;
         if (vq.size() > 0) chk({17'h0, vec}, {17'h0, vq.pop_front()});
         else chk({17'h0, vec}, 33'h100000000);
      end
      if (lcall === 1'b1) len++;
      if (prev && lcall !== 1'b1) chk(33'(len), 33'd4);
      prev = (lcall === 1'b1);
   end

   // ======================================================================
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, tmr_a, tmr_b, reti_req, slow, prev} = '0;
      {paddr, pwdata, pset} = '0;
      {pin_a_n, pin_b_n} = 2'b11;
      rng = 32'd17;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) rd(a[7:0], 33'h0);
      rd(8'h24, 33'h100000000);
      // timer a, then low service preempted by high timer b
      vq.push_back(16'h000B);
      apb(1'b1, `IVU_OFS_IE, 32'h82);
      pulse_tmr(2'b01);
      isr(1, `IVU_OFS_IE, 32'h82);
      rd(`IVU_OFS_TIMER_CONTROL_REG, 33'h0);
      apb(1'b1, `IVU_OFS_IP, 32'h08);
      apb(1'b1, `IVU_OFS_IE, 32'h98);
      vq.push_back(16'h0023);
      vq.push_back(16'h001B);
      @(posedge pclk) pset <= 21'h10;
      @(posedge pclk) pset <= 21'h0;
      wait_call(2);
      apb(1'b1, `IVU_OFS_PEND, 32'h0);
      pulse_tmr(2'b10);
      isr(3, `IVU_OFS_IE, 32'h98);
      isr(3, `IVU_OFS_IP, 32'h00);
      // simultaneous requests, one high
      apb(1'b1, `IVU_OFS_IE, 32'h00);
      apb(1'b1, `IVU_OFS_EE1, 32'h90);
      apb(1'b1, `IVU_OFS_EE2, 32'h40);
      apb(1'b1, `IVU_OFS_EP1, 32'h80);
      apb(1'b1, `IVU_OFS_PEND, 32'h00102400);
      rd(`IVU_OFS_PEND, 33'h00102400);
      vq.push_back(16'h006B);
      vq.push_back(16'h0053);
      vq.push_back(16'h00A3);
      apb(1'b1, `IVU_OFS_IE, 32'h80);
      isr(4, `IVU_OFS_PEND, 32'h00100400);
      isr(5, `IVU_OFS_PEND, 32'h00100000);
      isr(6, `IVU_OFS_PEND, 32'h0);
      // pin a falling edge, hardware clear
      apb(1'b1, `IVU_OFS_TIMER_CONTROL_REG, 32'h01);
      apb(1'b1, `IVU_OFS_IE, 32'h81);
      vq.push_back(16'h0003);
      set_pins(2'b10);
      repeat (2) @(posedge pclk);
      set_pins(2'b11);
      isr(7, `IVU_OFS_IE, 32'h81);
      rd(`IVU_OFS_TIMER_CONTROL_REG, 33'h01);
      // pin b level mode, global enable off then on
      apb(1'b1, `IVU_OFS_IE, 32'h04);
      set_pins(2'b01);
      rd(`IVU_OFS_TIMER_CONTROL_REG, 33'h09);
      set_pins(2'b11);
      rd(`IVU_OFS_TIMER_CONTROL_REG, 33'h01);
      vq.push_back(16'h0013);
      set_pins(2'b01);
      apb(1'b1, `IVU_OFS_IE, 32'h84);
      wait_call(8);
      set_pins(2'b11);
      isr(8, `IVU_OFS_IE, 32'h84);
      // random peripheral orders, fast and slow core
      apb(1'b1, `IVU_OFS_EE1, 32'hFF);
      apb(1'b1, `IVU_OFS_EE2, 32'hFF);
      apb(1'b1, `IVU_OFS_EP1, 32'h00);
      apb(1'b1, `IVU_OFS_IE, 32'hBF);
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         o = (rng[3:0] == 4'hF) ? 20 : 4 + int'(rng[3:0]);
         slow <= rng[4];
         vq.push_back(16'h0003 + 16'(o * 8));
         @(posedge pclk) pset <= 21'(1 << o);
         @(posedge pclk) pset <= 21'h0;
         isr(9 + i, `IVU_OFS_PEND, 32'h0);
      end
      repeat (20) @(posedge pclk);
      chk(33'(vq.size()), 33'h0);
      test_done();
   end
endmodule // tb_two_level_vectored_interrupt_unit
